// *** wind_cmd_pkg.sv ***
package wind_cmd_pkg;

  // clock and timing
  localparam int CLK_HZ        = 200_000_000;
  localparam int MS_TIME_US    = 1000;
  localparam int CYC_PER_MS    = (CLK_HZ / 1_000_000) * MS_TIME_US;
  localparam int RESP_MAX_US   = 1000;
  localparam int RESP_MAX_CYC  = (CLK_HZ / 1_000_000) * RESP_MAX_US;
  localparam int ID_SETTLE_CYC = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_CONFIG   = 8'h08;
  localparam logic [7:0] OFS_TIMING   = 8'h0C;
  localparam logic [7:0] OFS_ITEM     = 8'h10;
  localparam logic [7:0] OFS_TEXT_SEL = 8'h14;
  localparam logic [7:0] OFS_TEXT     = 8'h18;

  // command codes in the command register
  localparam logic [7:0] CMD_BURST_SEL   = 8'h01;
  localparam logic [7:0] CMD_TEMP_CORR   = 8'h02;
  localparam logic [7:0] CMD_TEL_REQ     = 8'h03;
  localparam logic [7:0] CMD_AUTO_SEL    = 8'h04;
  localparam logic [7:0] CMD_ITEM_APPEND = 8'h05;
  localparam logic [7:0] CMD_ITEM_REMOVE = 8'h06;
  localparam logic [7:0] CMD_DEF_STORE   = 8'h07;
  localparam logic [7:0] CMD_DEF_REPLACE = 8'h08;
  localparam logic [7:0] CMD_VSCALE      = 8'h09;
  localparam logic [7:0] CMD_DIR_CORR    = 8'h0A;
  localparam logic [7:0] CMD_ID_LINES    = 8'h0B;
  localparam logic [7:0] CMD_DUPLEX      = 8'h0C;
  localparam logic [7:0] CMD_INTERVAL    = 8'h0D;
  localparam logic [7:0] CMD_RESP_DELAY  = 8'h0E;

  // field positions
  localparam int CMD_CODE_LSB  = 16;
  localparam int TXT_SLOT_LSB  = 8;
  localparam int TXT_CHAR_LSB  = 16;

  // value ranges
  localparam logic [15:0] TEL_MIN    = 16'h0001;
  localparam logic [15:0] TEL_MAX    = 16'h000D;
  localparam logic [3:0]  TEL_USER   = 4'h6;
  localparam logic [4:0]  ITEM_MAX   = 5'h1E;
  localparam logic [15:0] STORE_KEY  = 16'h0002;
  localparam logic [15:0] VSCALE_MAX = 16'h07D0;
  localparam logic [15:0] DELAY_MAX  = 16'h03E8;
  localparam logic [5:0]  SLOT_NUM   = 6'h20;
  localparam int          SLOT_LEN   = 32;

  // reset values
  localparam logic [3:0]  BURST_RST    = 4'h2;
  localparam logic [3:0]  AUTO_RST     = 4'h0;
  localparam logic        TC_RST       = 1'b0;
  localparam logic        VT_RST       = 1'b1;
  localparam logic [10:0] VSCALE_RST   = 11'h41F;
  localparam logic        XI_RST       = 1'b0;
  localparam logic        DUPLEX_RST   = 1'b0;
  localparam logic [15:0] INTERVAL_RST = 16'h0001;
  localparam logic [9:0]  DELAY_RST    = 10'h000;

  // carriers
  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] param;
  } cmd_s;

  typedef struct packed {
    logic       user;
    logic [3:0] num;
  } tele_sel_s;

endpackage

// *** telegram_command_interpreter.sv ***
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module telegram_command_interpreter
  import wind_cmd_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
)
(
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // measurement and transmitter
  input  wire logic        BURST_DONE_I,
  input  wire logic        TX_READY_I,
  output logic             TX_VALID_O,
  output tele_sel_s        TX_SEL_O,
  // id lines, active low pins
  input  wire logic [2:0]  ID_LINE_N_I,
  // settings to the processing chain
  output logic [10:0]      VSCALE_O,
  output logic             TEMP_CORR_O,
  output logic             DIR_CORR_O,
  output logic [2:0]       INST_ID_O,
  output logic             ID_STORE_O
);

  localparam int MS_W = $clog2(MS_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  cmd_s        cmd;
  logic        cmd_go;
  logic [15:0] prm;

  // zero wait states, so the access phase always completes at once
  assign PREADY_O = 1'b1;
  assign addr_ok  = (PADDR_I == OFS_CMD) || (PADDR_I == OFS_STATUS) ||
                    (PADDR_I == OFS_CONFIG) || (PADDR_I == OFS_TIMING) ||
                    (PADDR_I == OFS_ITEM) || (PADDR_I == OFS_TEXT_SEL) ||
                    (PADDR_I == OFS_TEXT);
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
  assign rd_setup  = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign cmd       = cmd_s'(PWDATA_I[CMD_CODE_LSB+7:0]);
  assign cmd_go    = wr_en && (PADDR_I == OFS_CMD);
  assign prm       = cmd.param;

  ////////////////////////////////////////////////////////////////////////////////
  // settings
  logic [3:0]  burst_sel_r;
  logic [3:0]  auto_sel_r;
  logic        tc_r;
  logic        vt_r;
  logic [10:0] vscale_r;
  logic        xi_r;
  logic        duplex_r;
  logic [15:0] interval_r;
  logic [9:0]  delay_r;
  logic        cmd_bad_r;
  logic        tel_ok;

  assign tel_ok = (prm >= TEL_MIN) && (prm <= TEL_MAX);

  // each setting only moves on an in-range parameter
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      burst_sel_r <= BURST_RST;
      auto_sel_r  <= AUTO_RST;
      tc_r        <= TC_RST;
      vt_r        <= VT_RST;
      vscale_r    <= VSCALE_RST;
      xi_r        <= XI_RST;
      duplex_r    <= DUPLEX_RST;
      interval_r  <= INTERVAL_RST;
      delay_r     <= DELAY_RST;
      cmd_bad_r   <= 1'b0;
    end
    else if (cmd_go)
    begin
      cmd_bad_r <= 1'b1;
      case (cmd.code)
        CMD_BURST_SEL:
          if (tel_ok)
          begin
            burst_sel_r <= prm[3:0];
            cmd_bad_r   <= 1'b0;
          end
        CMD_TEMP_CORR:
          if (prm <= 16'h0001)
          begin
            tc_r      <= prm[0];
            cmd_bad_r <= 1'b0;
          end
        CMD_AUTO_SEL:
          if (prm <= TEL_MAX)
          begin
            auto_sel_r <= prm[3:0];
            cmd_bad_r  <= 1'b0;
          end
        CMD_VSCALE:
          if (prm <= VSCALE_MAX)
          begin
            vscale_r  <= prm[10:0];
            cmd_bad_r <= 1'b0;
          end
        CMD_DIR_CORR:
          if (prm <= 16'h0001)
          begin
            vt_r      <= prm[0];
            cmd_bad_r <= 1'b0;
          end
        CMD_ID_LINES:
          if (prm <= 16'h0001)
          begin
            xi_r      <= prm[0];
            cmd_bad_r <= 1'b0;
          end
        CMD_DUPLEX:
          if (prm <= 16'h0001)
          begin
            duplex_r  <= prm[0];
            cmd_bad_r <= 1'b0;
          end
        // a zero interval would wrap and fire only every 65536 ms, so it is refused
        CMD_INTERVAL:
          if (prm != 16'h0000)
          begin
            interval_r <= prm;
            cmd_bad_r  <= 1'b0;
          end
        CMD_RESP_DELAY:
          if (prm <= DELAY_MAX)
          begin
            delay_r   <= prm[9:0];
            cmd_bad_r <= 1'b0;
          end
        CMD_TEL_REQ:
          cmd_bad_r <= !tel_ok;
        CMD_ITEM_REMOVE:
          cmd_bad_r <= (prm > 16'(ITEM_MAX));
        CMD_DEF_STORE:
          cmd_bad_r <= (prm != STORE_KEY);
        CMD_ITEM_APPEND, CMD_DEF_REPLACE:
          cmd_bad_r <= 1'b0;
        default:
          cmd_bad_r <= 1'b1;
      endcase
    end
  end

  assign VSCALE_O    = vscale_r;
  assign TEMP_CORR_O = tc_r;
  assign DIR_CORR_O  = vt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // millisecond enable
  logic [MS_W-1:0] ms_cnt_r;
  logic            ms_tick;

  assign ms_tick = (ms_cnt_r == MS_W'(MS_CYCLES - 1));

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ms_cnt_r <= '0;
    else if (ms_tick)
      ms_cnt_r <= '0;
    else
      ms_cnt_r <= ms_cnt_r + MS_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // on-demand, burst and autonomous requests
  logic        dem_pend_r;
  logic [3:0]  dem_num_r;
  logic [9:0]  dly_cnt_r;
  logic        dem_go;
  logic        burst_pend_r;
  logic        auto_pend_r;
  logic [15:0] auto_cnt_r;
  logic        load;

  // demand goes out as soon as its delay has run
  assign dem_go = dem_pend_r && (dly_cnt_r == 10'h000);
  assign load   = !TX_VALID_O;

  // take the request and arm the delay
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      dem_pend_r <= 1'b0;
      dem_num_r  <= 4'h0;
      dly_cnt_r  <= 10'h000;
    end
    else if (cmd_go && (cmd.code == CMD_TEL_REQ) && tel_ok)
    begin
      dem_pend_r <= 1'b1;
      dem_num_r  <= prm[3:0];
      dly_cnt_r  <= delay_r;
    end
    else if (dem_go && load)
      dem_pend_r <= 1'b0;
    else if (dem_pend_r && ms_tick && (dly_cnt_r != 10'h000))
      dly_cnt_r <= dly_cnt_r - 10'h001;
  end

  // burst end sets the flag; a new burst wins over the clear
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      burst_pend_r <= 1'b0;
    else if (BURST_DONE_I)
      burst_pend_r <= 1'b1;
    else if (load && !dem_go)
      burst_pend_r <= 1'b0;
  end

  // interval timer runs only while enabled in full duplex
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      auto_cnt_r  <= 16'h0000;
      auto_pend_r <= 1'b0;
    end
    else if ((auto_sel_r == 4'h0) || !duplex_r)
    begin
      auto_cnt_r  <= 16'h0000;
      auto_pend_r <= 1'b0;
    end
    else if (ms_tick && (auto_cnt_r >= interval_r - 16'h0001))
    begin
      auto_cnt_r  <= 16'h0000;
      auto_pend_r <= 1'b1;
    end
    else
    begin
      if (ms_tick)
        auto_cnt_r <= auto_cnt_r + 16'h0001;
      if (load && !dem_go && !burst_pend_r)
        auto_pend_r <= 1'b0;
    end
  end

  // transmit slot: demand first, then burst, then autonomous
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      TX_VALID_O <= 1'b0;
      TX_SEL_O   <= '0;
    end
    else if (TX_VALID_O)
    begin
      if (TX_READY_I)
        TX_VALID_O <= 1'b0;
    end
    else if (dem_go || burst_pend_r || auto_pend_r)
    begin
      TX_VALID_O <= 1'b1;
      // number six selects the user telegram
      if (dem_go)
        TX_SEL_O <= '{user: dem_num_r == TEL_USER, num: dem_num_r};
      else if (burst_pend_r)
        TX_SEL_O <= '{user: burst_sel_r == TEL_USER, num: burst_sel_r};
      else
        TX_SEL_O <= '{user: auto_sel_r == TEL_USER, num: auto_sel_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // user telegram definitions
  logic [7:0] item_mem [0:29];
  logic [7:0] nv_mem   [0:29];
  logic [4:0] item_cnt_r;
  logic [4:0] nv_cnt_r;
  logic       is_app;
  logic       is_rep;
  logic       is_sto;

  assign is_app = cmd_go && (cmd.code == CMD_ITEM_APPEND) && (item_cnt_r < ITEM_MAX);
  assign is_rep = cmd_go && (cmd.code == CMD_DEF_REPLACE);
  assign is_sto = cmd_go && (cmd.code == CMD_DEF_STORE) && (prm == STORE_KEY);

  // one command carries one definition code
  always_ff @(posedge CLK_SYS_I)
  begin
    if (is_rep)
      item_mem[0] <= prm[7:0];
    else if (is_app)
      item_mem[item_cnt_r] <= prm[7:0];
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      item_cnt_r <= 5'h00;
    else if (is_rep)
      item_cnt_r <= 5'h01;
    else if (is_app)
      item_cnt_r <= item_cnt_r + 5'h01;
    else if (cmd_go && (cmd.code == CMD_ITEM_REMOVE) && (prm <= 16'(ITEM_MAX)))
      item_cnt_r <= (prm[4:0] >= item_cnt_r) ? 5'h00 : item_cnt_r - prm[4:0];
  end

  // snapshot copy into the retained store
  always_ff @(posedge CLK_SYS_I)
  begin
    if (is_sto)
      nv_mem <= item_mem;
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      nv_cnt_r <= 5'h00;
    else if (is_sto)
      nv_cnt_r <= item_cnt_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // text slots, indexed 1..32 in the write word
  logic [7:0]  txt_mem [0:1023];
  logic [5:0]  wr_slot;
  logic [10:0] rd_sel_r;
  logic [4:0]  item_sel_r;

  assign wr_slot = PWDATA_I[TXT_SLOT_LSB+5:TXT_SLOT_LSB];

  always_ff @(posedge CLK_SYS_I)
  begin
    if (wr_en && (PADDR_I == OFS_TEXT) && (wr_slot != 6'h00) && (wr_slot <= SLOT_NUM))
      txt_mem[{wr_slot[4:0] - 5'h01, PWDATA_I[TXT_CHAR_LSB+4:TXT_CHAR_LSB]}] <= PWDATA_I[7:0];
  end

  // read selectors for slot text and definition list
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rd_sel_r   <= 11'h000;
      item_sel_r <= 5'h00;
    end
    else if (wr_en && (PADDR_I == OFS_TEXT_SEL))
      rd_sel_r <= {PWDATA_I[TXT_SLOT_LSB+5:TXT_SLOT_LSB] - 6'h01,
                   PWDATA_I[TXT_CHAR_LSB+4:TXT_CHAR_LSB]};
    else if (wr_en && (PADDR_I == OFS_ITEM))
      item_sel_r <= PWDATA_I[4:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instrument id from the lines
  logic [2:0] id_s1_r;
  logic [2:0] id_s2_r;
  logic [2:0] id_s3_r;
  logic [2:0] id_pin_r;
  logic [3:0] settle_r;
  logic [2:0] id_nv_r;

  // three stages; a bit moves once the last two agree
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      id_s1_r  <= 3'h7;
      id_s2_r  <= 3'h7;
      id_s3_r  <= 3'h7;
      id_pin_r <= 3'h7;
    end
    else
    begin
      id_s1_r <= ID_LINE_N_I;
      id_s2_r <= id_s1_r;
      id_s3_r <= id_s2_r;
      for (int b = 0; b < 3; b++)
        if (id_s2_r[b] == id_s3_r[b])
          id_pin_r[b] <= id_s3_r[b];
    end
  end

  // sample once after release, low line means one
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      settle_r   <= 4'h0;
      id_nv_r    <= 3'h0;
      ID_STORE_O <= 1'b0;
    end
    else
    begin
      ID_STORE_O <= 1'b0;
      if (settle_r != 4'(ID_SETTLE_CYC))
      begin
        settle_r <= settle_r + 4'h1;
        if ((settle_r == 4'(ID_SETTLE_CYC - 1)) && xi_r)
        begin
          id_nv_r    <= ~id_pin_r;
          ID_STORE_O <= 1'b1;
        end
      end
    end
  end

  assign INST_ID_O = id_nv_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      PRDATA_O <= 32'h0000_0000;
    else if (rd_setup)
    begin
      if (PADDR_I == OFS_STATUS)
        PRDATA_O <= {8'h00, nv_cnt_r, id_nv_r, 3'h0, item_cnt_r,
                     5'h00, auto_pend_r, dem_pend_r, cmd_bad_r};
      else if (PADDR_I == OFS_CONFIG)
        PRDATA_O <= {5'h00, vscale_r, 4'h0, duplex_r, xi_r, vt_r, tc_r,
                     auto_sel_r, burst_sel_r};
      else if (PADDR_I == OFS_TIMING)
        PRDATA_O <= {interval_r, 6'h00, delay_r};
      else if (PADDR_I == OFS_ITEM)
        PRDATA_O <= {24'h000000, item_mem[item_sel_r]};
      else if (PADDR_I == OFS_TEXT)
        PRDATA_O <= {24'h000000, txt_mem[rd_sel_r[9:0]]};
      else
        PRDATA_O <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_req_now;
    cmd_go && (cmd.code == CMD_TEL_REQ) && tel_ok && (delay_r == 10'h000)
      && !TX_VALID_O && !dem_pend_r && !burst_pend_r && !auto_pend_r;
  endsequence

  sequence s_sent_now;
    ##2 TX_VALID_O && (TX_SEL_O.num == $past(prm[3:0], 2));
  endsequence

  AST_BURST_RANGE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (burst_sel_r >= 4'h1) && (burst_sel_r <= 4'hD)) else $error("burst select out of range");
  AST_TC_SET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    cmd_go && (cmd.code == CMD_TEMP_CORR) && (prm <= 16'h0001) |=> TEMP_CORR_O == $past(prm[0]))
    else $error("crosswind switch not taken");
  AST_REQ_FAST: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    s_req_now |-> s_sent_now) else $error("request reply late");
  AST_DELAY_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    dem_pend_r && (dly_cnt_r != 10'h000) |=> !(TX_VALID_O && $rose(TX_VALID_O) && !$past(burst_pend_r)
      && !$past(auto_pend_r))) else $error("reply sent before delay");
  AST_AUTO_GATE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!duplex_r || (auto_sel_r == 4'h0)) |=> !auto_pend_r) else $error("autonomous while off");
  AST_APPEND: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    is_app && !is_rep |=> (item_cnt_r == $past(item_cnt_r) + 5'h01)
      && (item_mem[$past(item_cnt_r)] == $past(prm[7:0]))) else $error("append lost");
  AST_REMOVE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    cmd_go && (cmd.code == CMD_ITEM_REMOVE) && (prm <= 16'(ITEM_MAX)) |=> item_cnt_r ==
      (($past(prm[4:0]) >= $past(item_cnt_r)) ? 5'h00 : $past(item_cnt_r) - $past(prm[4:0])))
    else $error("remove count wrong");
  AST_REPLACE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    is_rep |=> item_cnt_r == 5'h01) else $error("replace kept old items");
  AST_STORE_ONLY: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !is_sto |=> $stable(nv_cnt_r)) else $error("store without command");
  AST_USER_TEL: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    TX_VALID_O |-> TX_SEL_O.user == (TX_SEL_O.num == TEL_USER)) else $error("user flag wrong");
  AST_VSCALE_KEEP: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    cmd_go && (cmd.code == CMD_VSCALE) && (prm > VSCALE_MAX) |=> $stable(vscale_r))
    else $error("bad scale accepted");
  AST_ID_LOW: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    ID_STORE_O |-> INST_ID_O == ~$past(id_pin_r)) else $error("id polarity wrong");

endmodule
`default_nettype wire

// *** tx_sink_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tx_sink_model
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // telegram hand-off
  input  wire logic valid_i,
  input  wire logic slow_i,
  output logic      ready_o
);
  int         seed = 38;
  logic [3:0] wait_r;

  // slow mode stalls a random 1..8 cycles per telegram, prompt mode idles ready
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ready_o <= 1'b0;
      wait_r  <= 4'h0;
    end
    else if (valid_i && ready_o)
    begin
      ready_o <= !slow_i;
      wait_r  <= 4'($random(seed)) & 4'h7;
    end
    else if (valid_i && wait_r == 4'h0)
      ready_o <= 1'b1;
    else if (valid_i)
      wait_r <= wait_r - 4'h1;
    else
      ready_o <= !slow_i;
  end
endmodule
`default_nettype wire

// *** telegram_command_interpreter_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module telegram_command_interpreter_tb
  import wind_cmd_pkg::*;
;
  localparam int MS = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        burst = 1'b0;
  logic        slow = 1'b0;
  logic [2:0]  id_n = 3'h7;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, perr, tx_valid, tx_ready, tc, dc, id_st;
  logic        stored = 1'b0;
  logic [10:0] vscale;
  logic [2:0]  inst_id;
  logic [7:0]  it [3];
  tele_sel_s   tx_sel;
  tele_sel_s   exp_q [$];
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          gap = 0;
  int          last_hs = 0;
  int          seed = 38;
  logic [23:0] tbl [10] = '{{CMD_BURST_SEL, 16'h000D}, {CMD_BURST_SEL, 16'h000E},
    {CMD_VSCALE, 16'h07D0}, {CMD_VSCALE, 16'h07D1}, {CMD_TEMP_CORR, 16'h0001},
    {CMD_TEMP_CORR, 16'h0002}, {CMD_DIR_CORR, 16'h0000}, {CMD_DIR_CORR, 16'h0002},
    {CMD_AUTO_SEL, 16'h000D}, {CMD_AUTO_SEL, 16'h000E}};

  telegram_command_interpreter #(.MS_CYCLES(MS)) dut (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .BURST_DONE_I(burst),
    .TX_READY_I(tx_ready), .TX_VALID_O(tx_valid), .TX_SEL_O(tx_sel), .ID_LINE_N_I(id_n),
    .VSCALE_O(vscale), .TEMP_CORR_O(tc), .DIR_CORR_O(dc), .INST_ID_O(inst_id),
    .ID_STORE_O(id_st));

  tx_sink_model sink (.clk_i(clk), .rst_n_i(rst_n), .valid_i(tx_valid), .slow_i(slow),
    .ready_o(tx_ready));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  always #2.5 clk = ~clk;

  // hang guard and sticky id store flag
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (id_st === 1'b1)
      stored <= 1'b1;
    if (cyc == 30000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  // every accepted telegram must match the oldest expectation
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      gap = cyc - last_hs;
      last_hs = cyc;
      if (exp_q.size() == 0)
      begin
        error_cnt++;
        $display("wrong value at %0t: unexpected telegram", $time);
      end
      else
        chk_tx(tx_sel, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_tx(input tele_sel_s got, input tele_sel_s exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: telegram %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no local limit: a stuck slave is caught by the cycle guard
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // code and parameter framed in one word
  task automatic cmd(input logic [7:0] c, input logic [15:0] p);
    apb(1'b1, OFS_CMD, {8'h00, c, p});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || tx_valid !== 1'b0) && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(exp_q.size()), 32'h0);
  endtask

  // request a telegram and bound the cycles until the answer starts
  task automatic req(input logic [15:0] p, input int lo, input int hi);
    int n;
    n = 0;
    exp_q.push_back({p[3:0] == TEL_USER, p[3:0]});
    cmd(CMD_TEL_REQ, p);
    while (tx_valid !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
    wait_idle();
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    id_n <= 3'($random(seed));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cmd(CMD_ID_LINES, 16'h0001);
    repeat (10) @(posedge clk);
    chk({29'h0, inst_id}, {29'h0, ~id_n});
    chk(32'(stored), 32'h1);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, {5'h00, 11'h41F, 4'h0, 4'h6, 4'h0, 4'h2});
    chk({vscale, tc, dc}, {11'h41F, 1'b0, 1'b1});
    for (int i = 0; i < 10; i++)
      cmd(tbl[i][23:16], tbl[i][15:0]);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, {5'h00, 11'h7D0, 4'h0, 4'h5, 4'hD, 4'hD});
    chk({vscale, tc, dc}, {11'h7D0, 1'b1, 1'b0});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h1);
    cmd(CMD_AUTO_SEL, 16'h0000);
    for (int i = 1; i <= 13; i++)
    begin
      slow <= i[0];
      req(16'(i), 1, MS - 1);
    end
    slow <= 1'b0;
    // request out of range is ignored
    cmd(CMD_TEL_REQ, 16'h000E);
    cmd(CMD_RESP_DELAY, 16'h0002);
    apb(1'b0, OFS_TIMING, 32'h0);
    chk(rd, 32'h0001_0002);
    req(16'h0005, MS + 1, 3 * MS + 4);
    cmd(CMD_RESP_DELAY, 16'h0000);
    exp_q.push_back({1'b0, 4'hD});
    burst <= 1'b1;
    @(posedge clk);
    burst <= 1'b0;
    wait_idle();
    cmd(CMD_INTERVAL, 16'h0003);
    cmd(CMD_AUTO_SEL, 16'h0007);
    repeat (200) @(posedge clk);
    exp_q.push_back({1'b0, 4'h7});
    exp_q.push_back({1'b0, 4'h7});
    cmd(CMD_DUPLEX, 16'h0001);
    wait_idle();
    cmd(CMD_AUTO_SEL, 16'h0000);
    chk(32'(gap), 32'(3 * MS));
    for (int k = 0; k < 3; k++)
    begin
      it[k] = 8'($random(seed));
      cmd(CMD_ITEM_APPEND, {8'h00, it[k]});
    end
    cmd(CMD_ITEM_REMOVE, 16'h0001);
    cmd(CMD_ITEM_REMOVE, 16'h001F);
    cmd(CMD_ITEM_REMOVE, 16'h0000);
    apb(1'b1, OFS_ITEM, 32'h1);
    apb(1'b0, OFS_ITEM, 32'h0);
    chk(32'(rd[7:0]), 32'(it[1]));
    cmd(CMD_DEF_STORE, 16'h0003);
    cmd(CMD_DEF_STORE, STORE_KEY);
    cmd(CMD_DEF_REPLACE, 16'h0044);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'({rd[23:19], rd[12:8]}), {22'h0, 5'h02, 5'h01});
    apb(1'b1, OFS_ITEM, 32'h0);
    apb(1'b0, OFS_ITEM, 32'h0);
    chk(32'(rd[7:0]), 32'h44);
    for (int s = 1; s <= 32; s += 31)
    begin
      apb(1'b1, OFS_TEXT, {11'h0, 5'h1F, 2'h0, 6'(s), 8'(s + 8'h40)});
      apb(1'b1, OFS_TEXT_SEL, {11'h0, 5'h1F, 2'h0, 6'(s), 8'h00});
      apb(1'b0, OFS_TEXT, 32'h0);
      chk(32'(rd[7:0]), 32'(8'(s + 8'h40)));
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({rd[30:0], perr}, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
